// file: core/sbc_buf2.sv
// sbc_buf2: two-entry buffer on the read-data path
// assumes the caller holds data steady while valid and not ready
`timescale 1ns/1ps
`include "sbc_map.svh"
module sbc_buf2 (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          ce,
    sbc_stream_if.snk          in_if,
    output logic               out_valid,
    input  wire logic          out_ready,
    output sbc_pkg::sbc_word_t out_data
);
    import sbc_pkg::*;

    sbc_word_t  mem_r [`SBC_BUF_D];
    logic       wp_r;
    logic       rp_r;
    logic [1:0] cnt_r;
    logic       push;
    logic       pop;

    assign in_if.ready = (cnt_r != 2'(`SBC_BUF_D));
    assign out_valid   = (cnt_r != 2'h0);
    assign out_data    = mem_r[rp_r];
    assign push        = ce && in_if.valid && in_if.ready;
    assign pop         = ce && out_valid && out_ready;

    genvar g;
    generate
        for (g = 0; g < `SBC_BUF_D; g++) begin : g_slot
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn)
                    mem_r[g] <= '0;
                else if (push && (wp_r == 1'(g)))
                    mem_r[g] <= in_if.data;
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push)
                wp_r <= ~wp_r;
            if (pop)
                rp_r <= ~rp_r;
            cnt_r <= cnt_r + 2'(push) - 2'(pop);
        end
    end
endmodule

// file: core/sbc_ctrl.sv
// sbc_ctrl: two-wire serial-bus controller for the configuration eeprom
// assumes scl and sda are open-drain pins with external pullups, and that
// perst_n and global_reset_n arrive asynchronously from pins
// Behaviour
// - sample scl pullup when later reset releases
// - pullup seen sets serial_bus_present, status bit 3
// - disable strobe clears present, stops bus immediately
// - pulldown at reset: bus stays off until the next reset release
// - scl driven, sampled only at reset release; sda driven and sampled
// - both lines open-drain: pull low or release
// - controller starts every transfer; eeprom only answers
// - scl toggles at about 60 kHz
// - idle bus: scl released, no edges
// - fetch identification and defaults from eeprom
// - without eeprom, defaults flagged ready anyway
// - address nack sets no_ack_error, status bit 1
// - auto multibyte read after reset; singles by software
// - read: start, addr+w, word, restart, addr+r, data
// - word_address_omit drops word byte and its ack
`timescale 1ns/1ps
`include "sbc_map.svh"
module sbc_ctrl (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          ce,
    input  wire logic          perst_n,
    input  wire logic          global_reset_n,
    input  wire logic          scl_i,
    output logic               scl_o,
    output logic               scl_oe,
    input  wire logic          sda_i,
    output logic               sda_o,
    output logic               sda_oe,
    input  wire logic          sb_disable,
    input  wire logic          word_address_omit,
    input  wire logic          err_clear,
    output logic               serial_bus_present,
    output logic               no_ack_error,
    output logic [7:0]         sb_status,
    output logic               defaults_ready,
    input  wire logic          cmd_valid,
    output logic               cmd_ready,
    input  wire logic          cmd_write,
    input  wire logic [7:0]    cmd_word,
    input  wire logic [7:0]    cmd_wdata,
    output logic               cmd_done,
    output logic               rd_valid,
    input  wire logic          rd_ready,
    output sbc_pkg::sbc_word_t rd_data
);
    import sbc_pkg::*;

    localparam logic [`SBC_QTR_W-1:0] QTR_LAST = `SBC_QTR_W'(`SBC_QTR_CYC - 1);

    sbc_state_e            st_r;
    sbc_seq_e              seq_r;
    logic [1:0]            perst_m_r, global_reset_n_m_r, scl_m_r, sda_m_r;
    logic                  rst_ok, rst_ok_d_r, rst_rise;
    logic                  present_r, err_r, ready_r, auto_pend_r;
    logic                  auto_r, wr_r, omit_r, pushed_r, done_r;
    logic [`SBC_QTR_W-1:0] qcnt_r;
    logic [1:0]            q_r;
    logic [3:0]            bit_r;
    logic [7:0]            tx_r, rx_r, word_r, left_r, wdata_r;
    logic                  ack_r, scl_oe_r, sda_oe_r, scl_nxt, sda_nxt;
    logic                  tick, stall, byte_end, q_end, start_go;
    sbc_stream_if          push_if ();

    // second flop only: the first stage of each pair feeds nothing else
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            perst_m_r <= 2'h0;
            global_reset_n_m_r  <= 2'h0;
            scl_m_r   <= 2'h3;
            sda_m_r   <= 2'h3;
        end else if (ce) begin
            perst_m_r <= {perst_m_r[0], perst_n};
            global_reset_n_m_r  <= {global_reset_n_m_r[0], global_reset_n};
            scl_m_r   <= {scl_m_r[0], scl_i};
            sda_m_r   <= {sda_m_r[0], sda_i};
        end
    end

    assign rst_ok   = perst_m_r[1] && global_reset_n_m_r[1];
    assign rst_rise = rst_ok && !rst_ok_d_r;

    function automatic logic [7:0] tx_byte(sbc_seq_e s, logic [7:0] w,
                                           logic [7:0] d);
        unique case (s)
            SQ_ADDRW: tx_byte = (`SBC_TGT_ADDR) & 8'hFE;
            SQ_ADDRR: tx_byte = (`SBC_TGT_ADDR) | 8'h01;
            SQ_WORD:  tx_byte = w;
            SQ_DATAW: tx_byte = d;
            SQ_DATAR: tx_byte = 8'hFF;
        endcase
    endfunction

    // bus clock: quarter-period counter on the core clock
    assign stall    = (st_r == SBC_RECV) && (bit_r == 4'h8) && (q_r == 2'h0)
                      && !pushed_r;
    assign tick     = (st_r != SBC_IDLE) && !stall && (qcnt_r == QTR_LAST);
    assign q_end    = tick && (q_r == 2'h3);
    assign byte_end = q_end && (bit_r == 4'h8);
    assign start_go = (st_r == SBC_IDLE) && rst_ok && present_r
                      && (auto_pend_r || cmd_valid);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            qcnt_r <= '0;
        else if (ce) begin
            if ((st_r == SBC_IDLE) || stall || tick)
                qcnt_r <= '0;
            else
                qcnt_r <= qcnt_r + `SBC_QTR_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            rst_ok_d_r <= 1'b0;
        else if (ce)
            rst_ok_d_r <= rst_ok;
    end

    // detection and enable
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            present_r   <= 1'b0;
            auto_pend_r <= 1'b0;
            ready_r     <= 1'b0;
        end else if (ce) begin
            if (!rst_ok) begin
                present_r   <= 1'b0;
                auto_pend_r <= 1'b0;
                ready_r     <= 1'b0;
            end else if (rst_rise) begin
                present_r   <= scl_m_r[1];
                auto_pend_r <= scl_m_r[1];
                ready_r     <= !scl_m_r[1];
            end else if (sb_disable) begin
                present_r   <= 1'b0;
                auto_pend_r <= 1'b0;
                ready_r     <= 1'b1;
            end else begin
                if (start_go)
                    auto_pend_r <= 1'b0;
                if ((st_r == SBC_STOP) && q_end && auto_r)
                    ready_r <= 1'b1;
            end
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            err_r <= 1'b0;
        else if (ce) begin
            if (byte_end && (st_r == SBC_SEND) && ack_r
                && ((seq_r == SQ_ADDRW) || (seq_r == SQ_ADDRR)))
                err_r <= 1'b1;
            else if (err_clear)
                err_r <= 1'b0;
        end
    end

    // transfer sequencer; no target can start anything here
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r    <= SBC_IDLE;
            seq_r   <= SQ_ADDRW;
            q_r     <= 2'h0;
            bit_r   <= 4'h0;
            tx_r    <= 8'h00;
            rx_r    <= 8'h00;
            word_r  <= 8'h00;
            wdata_r <= 8'h00;
            left_r  <= 8'h00;
            ack_r   <= 1'b1;
            auto_r  <= 1'b0;
            wr_r    <= 1'b0;
            omit_r  <= 1'b0;
            done_r  <= 1'b0;
        end else if (ce) begin
            done_r <= 1'b0;
            if (!rst_ok || sb_disable) begin
                st_r <= SBC_IDLE;
                q_r  <= 2'h0;
            end else if (start_go) begin
                st_r    <= SBC_START;
                auto_r  <= auto_pend_r;
                wr_r    <= !auto_pend_r && cmd_write;
                word_r  <= auto_pend_r ? 8'h00 : cmd_word;
                wdata_r <= cmd_wdata;
                left_r  <= auto_pend_r ? `SBC_LOAD_BYTES : 8'h01;
                omit_r  <= word_address_omit;
                seq_r   <= (word_address_omit && (auto_pend_r || !cmd_write))
                           ? SQ_ADDRR : SQ_ADDRW;
                q_r     <= 2'h0;
            end else if (tick) begin
                q_r <= q_r + 2'h1;
                if (q_r == 2'h2 && (st_r == SBC_SEND || st_r == SBC_RECV)) begin
                    if (bit_r == 4'h8)
                        ack_r <= sda_m_r[1];
                    else if (st_r == SBC_RECV)
                        rx_r <= {rx_r[6:0], sda_m_r[1]};
                end
                if (q_r == 2'h3) begin
                    bit_r <= bit_r + 4'h1;
                    if (st_r == SBC_SEND && bit_r != 4'h8)
                        tx_r <= {tx_r[6:0], 1'b0};
                    if (st_r == SBC_START) begin
                        st_r  <= SBC_SEND;
                        bit_r <= 4'h0;
                        tx_r  <= tx_byte(seq_r, word_r, wdata_r);
                    end else if (st_r == SBC_STOP) begin
                        st_r   <= SBC_IDLE;
                        done_r <= !auto_r;
                    end else if (bit_r == 4'h8) begin
                        bit_r <= 4'h0;
                        if (st_r == SBC_RECV) begin
                            word_r <= word_r + 8'h01;
                            left_r <= left_r - 8'h01;
                            if (left_r == 8'h01)
                                st_r <= SBC_STOP;
                        end else if (ack_r) begin
                            st_r <= SBC_STOP;
                        end else begin
                            unique case (seq_r)
                                SQ_ADDRW: begin
                                    seq_r <= omit_r ? SQ_DATAW : SQ_WORD;
                                    tx_r  <= omit_r ? wdata_r : word_r;
                                end
                                SQ_WORD: begin
                                    seq_r <= wr_r ? SQ_DATAW : SQ_ADDRR;
                                    tx_r  <= wdata_r;
                                    if (!wr_r)
                                        st_r <= SBC_START;
                                end
                                SQ_ADDRR: begin
                                    seq_r <= SQ_DATAR;
                                    st_r  <= SBC_RECV;
                                end
                                SQ_DATAW, SQ_DATAR: st_r <= SBC_STOP;
                            endcase
                        end
                    end
                end
            end
        end
    end

    // read byte handed to the buffer before the ack slot; holds scl low
    assign push_if.valid = stall;
    assign push_if.data  = {auto_r, word_r, rx_r};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            pushed_r <= 1'b0;
        else if (ce) begin
            if (push_if.valid && push_if.ready)
                pushed_r <= 1'b1;
            else if (st_r != SBC_RECV || bit_r != 4'h8)
                pushed_r <= 1'b0;
        end
    end

    // line drive: sda is held at q0 so data bits never move with scl high; only start and stop move it then
    always_comb begin
        scl_nxt = (q_r < 2'h2);
        sda_nxt = sda_oe_r;
        unique case (st_r)
            SBC_IDLE: begin
                scl_nxt = 1'b0;
                sda_nxt = 1'b0;
            end
            SBC_START:
                if (q_r != 2'h0)
                    sda_nxt = (q_r == 2'h3);
            SBC_SEND:
                if (q_r != 2'h0)
                    sda_nxt = (bit_r != 4'h8) && !tx_r[7];
            SBC_RECV:
                if (q_r != 2'h0)
                    sda_nxt = (bit_r == 4'h8) && (left_r != 8'h01);
            SBC_STOP:
                if (q_r != 2'h0)
                    sda_nxt = (q_r != 2'h3);
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (ce) begin
            scl_oe_r <= scl_nxt && (st_r != SBC_IDLE) && !sb_disable;
            sda_oe_r <= sda_nxt && (st_r != SBC_IDLE) && !sb_disable;
        end
    end

    assign scl_o  = 1'b0;
    assign sda_o  = 1'b0;
    assign scl_oe = scl_oe_r;
    assign sda_oe = sda_oe_r;

    assign serial_bus_present = present_r;
    assign no_ack_error       = err_r;
    assign defaults_ready     = ready_r;
    assign cmd_ready          = (st_r == SBC_IDLE) && rst_ok && ready_r
                                && !auto_pend_r;
    assign cmd_done           = done_r;

    always_comb begin
        sb_status                   = `SBC_STATUS_RST;
        sb_status[`SBC_PRESENT_BIT] = present_r;
        sb_status[`SBC_NOACK_BIT]   = err_r;
        sb_status[`SBC_OMIT_BIT]    = word_address_omit;
    end

    sbc_buf2 u_buf (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (ce),
        .in_if     (push_if.snk),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    AST_DETECT: assert property (@(posedge clk) disable iff (!rstn)
        (ce && rst_rise && !sb_disable) |=> present_r == $past(scl_m_r[1]))
        else $error("presence not taken from scl at reset release");
    AST_DISABLE: assert property (@(posedge clk) disable iff (!rstn)
        (ce && sb_disable && !rst_rise) |=> !present_r && st_r == SBC_IDLE
            ##1 !scl_oe && !sda_oe)
        else $error("disable did not stop the bus");
    AST_PULLDOWN: assert property (@(posedge clk) disable iff (!rstn)
        (!present_r && !rst_rise) |=> st_r == SBC_IDLE)
        else $error("transfer without a detected bus");
    AST_IDLE: assert property (@(posedge clk) disable iff (!rstn)
        (ce && st_r == SBC_IDLE) [*2] |=> !scl_oe && !sda_oe)
        else $error("line driven while idle");
    AST_RATE: assert property (@(posedge clk) disable iff (!rstn)
        (ce && tick) |=> qcnt_r == '0 ##1 (!$past(ce) || $past(stall) ||
            $past(st_r) == SBC_IDLE || qcnt_r == `SBC_QTR_W'(1)))
        else $error("quarter counter off");
    AST_NACK: assert property (@(posedge clk) disable iff (!rstn)
        (ce && byte_end && st_r == SBC_SEND && ack_r && seq_r == SQ_ADDRW)
            |=> err_r ##1 (err_r || $past(err_clear)))
        else $error("address nack not flagged");
    AST_OMIT: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == SBC_SEND && seq_r == SQ_WORD) |-> !omit_r)
        else $error("word address sent while omitted");
    AST_SDA_STABLE: assert property (@(posedge clk) disable iff (!rstn)
        ((st_r == SBC_SEND || st_r == SBC_RECV) && !scl_oe_r && ce
            && !sb_disable) |=> $stable(sda_oe_r))
        else $error("sda moved while scl high");
    AST_LAST_NACK: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == SBC_RECV && bit_r == 4'h8 && q_r == 2'h2 && left_r == 8'h01)
            |-> !sda_oe_r)
        else $error("last byte acknowledged");
endmodule

// file: core/sbc_map.svh
// sbc_map.svh: offsets, bit positions, reset values and timing counts
// assumes a 40 MHz core clock; included by the package and the modules
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH
`define SBC_CLK_NS       25
`define SBC_SCL_NS       16667
`define SBC_QTR_CYC      (((`SBC_SCL_NS) / 4) / (`SBC_CLK_NS))
`define SBC_QTR_W        8
`define SBC_TGT_ADDR     8'hA0
`define SBC_NOACK_BIT    1
`define SBC_PRESENT_BIT  3
`define SBC_OMIT_BIT     7
`define SBC_LOAD_BYTES   8'h1B
`define SBC_BUF_W        17
`define SBC_BUF_D        2
`define SBC_STATUS_RST   8'h00
`endif

// file: core/sbc_pkg.sv
// sbc_pkg: types shared by the serial-bus controller modules
// assumes sbc_map.svh is on the include path
`include "sbc_map.svh"
package sbc_pkg;
    typedef enum {SBC_IDLE, SBC_START, SBC_SEND, SBC_RECV, SBC_STOP} sbc_state_e;
    typedef enum {SQ_ADDRW, SQ_WORD, SQ_DATAW, SQ_ADDRR, SQ_DATAR} sbc_seq_e;
    // {auto_flag, word_address, data}
    typedef logic [`SBC_BUF_W-1:0] sbc_word_t;
endpackage

// file: core/sbc_stream_if.sv
// sbc_stream_if: valid/ready word stream between the controller and its buffer
// assumes both ends share one clock
`timescale 1ns/1ps
interface sbc_stream_if;
    logic                valid;
    logic                ready;
    sbc_pkg::sbc_word_t  data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// file: dv/eeprom_serial_bus_controller_tb.sv
// eeprom_serial_bus_controller_tb: self-checking bench for sbc_ctrl
// assumes sbc_pkg compiled first; lines pulled up unless someone pulls low
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    miscompares++; $display("mismatch %s exp %0h got %0h", nm, e, g); \
    end end
module eeprom_serial_bus_controller_tb;
    import sbc_pkg::*;
    logic       clk, rstn, ce, perst_n, global_reset_n, scl_pd, sda_pd;
    logic       scl_o, scl_oe, sda_o, sda_oe, sb_disable, word_address_omit;
    logic       err_clear, serial_bus_present, no_ack_error, defaults_ready;
    logic       cmd_valid, cmd_ready, cmd_write, cmd_done, rd_valid, rd_ready;
    logic       nack_addr, busy_seen;
    logic [7:0] sb_status, cmd_word, cmd_wdata, w, d;
    sbc_word_t  rd_data, got;
    wire logic  scl_w, sda_w;
    int         miscompares = 0, num_checks = 0, cyc = 0, last_fall = 0, gap;
    assign scl_w = !(scl_oe | scl_pd);
    assign sda_w = !(sda_oe | sda_pd);
    sbc_ctrl sbc_ctrl_i (.clk(clk), .rstn(rstn), .ce(ce), .perst_n(perst_n),
        .global_reset_n(global_reset_n), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
        .sb_disable(sb_disable), .word_address_omit(word_address_omit),
        .err_clear(err_clear), .serial_bus_present(serial_bus_present),
        .no_ack_error(no_ack_error), .sb_status(sb_status),
        .defaults_ready(defaults_ready), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_word(cmd_word),
        .cmd_wdata(cmd_wdata), .cmd_done(cmd_done), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data));
    sbc_eeprom_model sbc_eeprom_model_i (.scl(scl_w), .sda(sda_w),
        .nack_addr(nack_addr), .sda_pd(sda_pd));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // tests need about 72k cycles; the ceiling leaves some margin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 100000) begin
            miscompares++;
            report_and_stop();
        end
    end
    always @(negedge scl_w) begin
        gap = cyc - last_fall;
        last_fall = cyc;
    end
    function automatic logic sel(input int k);
        case (k)
            0: return cmd_done;
            1: return scl_oe;
            2: return no_ack_error;
            default: return defaults_ready;
        endcase
    endfunction
    function automatic logic [7:0] mem0(input logic [7:0] a);
        return a ^ 8'h5A;
    endfunction
    task automatic wait_for(input int k, input int lim);
        for (int i = 0; i < lim && sel(k) !== 1'b1; i++) @(negedge clk);
    endtask
    task automatic at_edge();
        @(posedge clk);
        #2;
    endtask
    task automatic cmd(input logic wr, input logic [7:0] wa,
                       input logic [7:0] wd);
        at_edge();
        sbc_eeprom_model_i.seen.delete();
        cmd_write = wr;
        cmd_word = wa;
        cmd_wdata = wd;
        cmd_valid = 1'b1;
        for (int i = 0; i < 200000 && cmd_ready !== 1'b1; i++) @(negedge clk);
        at_edge();
        cmd_valid = 1'b0;
    endtask
    task automatic get(output sbc_word_t v);
        at_edge();
        rd_ready = 1'b1;
        for (int i = 0; i < 1000 && rd_valid !== 1'b1; i++) @(negedge clk);
        v = rd_data;
        at_edge();
        rd_ready = 1'b0;
    endtask
    task automatic seen3(input int n, input logic [7:0] b0, b1, b2);
        logic [7:0] e [3];
        e = '{b0, b1, b2};
        `CHK("seen count", n, sbc_eeprom_model_i.seen.size())
        for (int i = 0; i < n; i++)
            `CHK("seen byte", e[i], sbc_eeprom_model_i.seen[i])
    endtask
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        {rstn, perst_n, global_reset_n, scl_pd, sb_disable} = 5'h00;
        {word_address_omit, err_clear, cmd_valid, cmd_write, rd_ready} = 5'h00;
        {ce, nack_addr} = 2'h3;
        cmd_word = 8'h00;
        cmd_wdata = 8'h00;
        void'($urandom(32'he1b6f1af));
        repeat (20) @(posedge clk);
        #2 rstn = 1'b1;
        // pulldown seen at the first release, pullup at the later one
        repeat (5) at_edge();
        perst_n = 1'b1;
        repeat (5) at_edge();
        {scl_pd, global_reset_n} = 2'h3;
        repeat (10) at_edge();
        scl_pd = 1'b0;
        @(negedge clk);
        `CHK("present", 1'b0, serial_bus_present)
        wait_for(3, 100);
        `CHK("defaults", 1'b1, defaults_ready)
        cmd(1'b0, 8'h10, 8'h00);
        busy_seen = 1'b0;
        repeat (3000) begin
            @(negedge clk);
            busy_seen |= scl_oe | sda_oe | cmd_done;
        end
        `CHK("bus quiet", 1'b0, busy_seen)
        at_edge();
        {perst_n, global_reset_n, scl_pd} = 3'h1;
        repeat (10) at_edge();
        global_reset_n = 1'b1;
        repeat (10) at_edge();
        scl_pd = 1'b0;
        repeat (10) at_edge();
        sbc_eeprom_model_i.seen.delete();
        perst_n = 1'b1;
        repeat (8) @(negedge clk);
        `CHK("present", 1'b1, serial_bus_present)
        `CHK("status3", 1'b1, sb_status[3])
        `CHK("busy ready", 1'b0, cmd_ready)
        wait_for(2, 20000);
        `CHK("noack", 1'b1, no_ack_error)
        `CHK("status1", 1'b1, sb_status[1])
        seen3(1, 8'hA0, 8'h00, 8'h00);
        wait_for(3, 5000);
        `CHK("defaults", 1'b1, defaults_ready)
        at_edge();
        {err_clear, nack_addr} = 2'h2;
        at_edge();
        err_clear = 1'b0;
        @(negedge clk);
        `CHK("noack clr", 1'b0, no_ack_error)
        w = $urandom;
        d = $urandom;
        cmd(1'b1, w, d);
        wait_for(0, 40000);
        `CHK("wr done", 1'b1, cmd_done)
        `CHK("mem", d, sbc_eeprom_model_i.mem[w])
        seen3(3, 8'hA0, w, d);
        `CHK("scl period", 664, gap)
        `CHK("pins low", 2'h0, {scl_o, sda_o})
        cmd(1'b0, w, 8'h00);
        wait_for(0, 40000);
        `CHK("rd done", 1'b1, cmd_done)
        seen3(3, 8'hA0, w, 8'hA1);
        at_edge();
        word_address_omit = 1'b1;
        cmd(1'b0, 8'h00, 8'h00);
        wait_for(0, 40000);
        `CHK("status7", 1'b1, sb_status[7])
        seen3(1, 8'hA1, 8'h00, 8'h00);
        get(got);
        `CHK("rd word", {1'b0, w, d}, got)
        get(got);
        `CHK("omit data", mem0(w + 8'h01), got[7:0])
        `CHK("auto flag", 1'b0, got[16])
        `CHK("rd empty", 1'b0, rd_valid)
        at_edge();
        word_address_omit = 1'b0;
        cmd(1'b0, w, 8'h00);
        wait_for(1, 2000);
        repeat (3000) @(negedge clk);
        // a half bit is 332 cycles, so an unfrozen bus would move in 400
        at_edge();
        ce = 1'b0;
        w = {6'h00, scl_oe, sda_oe};
        repeat (400) at_edge();
        `CHK("frozen", w, {6'h00, scl_oe, sda_oe})
        ce = 1'b1;
        at_edge();
        sb_disable = 1'b1;
        at_edge();
        sb_disable = 1'b0;
        repeat (3) @(negedge clk);
        `CHK("lines released", 2'h0, {scl_oe, sda_oe})
        `CHK("present off", 1'b0, serial_bus_present)
        report_and_stop();
    end
endmodule

// file: dv/sbc_eeprom_model.sv
// sbc_eeprom_model: behavioural serial eeprom answering at address A0h
// assumes scl and sda are wired-and nets with pullups in the bench
`timescale 1ns/1ps
module sbc_eeprom_model (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic nack_addr,
    output logic      sda_pd
);
    logic [7:0] mem [256];
    logic [7:0] seen [$];
    logic [7:0] sh;
    logic [7:0] ptr;
    logic       act, rx, first, wordp, in_ack, ack, go_tx, mack;
    int         cnt;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
        sda_pd = 1'b0;
        act = 1'b0;
        in_ack = 1'b0;
        ptr = 8'h00;
    end
    // start or restart: new frame, expect an address byte
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            act = 1'b1;
            rx = 1'b1;
            first = 1'b1;
            cnt = 0;
            in_ack = 1'b0;
            sda_pd = 1'b0;
        end
    end
    always @(posedge sda) if (scl === 1'b1) act = 1'b0;
    always @(posedge scl) begin
        if (act && !in_ack && cnt < 8) begin
            if (rx) sh = {sh[6:0], sda};
            cnt++;
        end else if (act && in_ack && !rx) mack = !sda;
    end
    // only pulls low, and only while scl is low; answers, never starts
    always @(negedge scl) begin
        if (!act) sda_pd = 1'b0;
        else if (in_ack) begin
            in_ack = 1'b0;
            cnt = 0;
            sda_pd = 1'b0;
            if (rx && !ack) act = 1'b0;
            else if (rx && go_tx) rx = 1'b0;
            else if (!rx) begin
                ptr++;
                if (!mack) act = 1'b0;
            end
            if (act && !rx) sda_pd = !mem[ptr][7];
        end else if (cnt == 8) begin
            in_ack = 1'b1;
            sda_pd = 1'b0;
            if (rx) begin
                seen.push_back(sh);
                ack = 1'b1;
                go_tx = 1'b0;
                if (first) begin
                    first = 1'b0;
                    wordp = !sh[0];
                    go_tx = sh[0];
                    ack = (sh[7:1] == 7'h50) && !nack_addr;
                end else if (wordp) begin
                    ptr = sh;
                    wordp = 1'b0;
                end else begin
                    mem[ptr] = sh;
                    ptr++;
                end
                sda_pd = ack;
            end
        end else if (!rx) sda_pd = !mem[ptr][7-cnt];
    end
endmodule
